/* File: pkg/fhd_defines.vh */
// Constants for the flash host interface with die select
// ==========================================================
// What this block does
// - Reset and power-up start in asynchronous page read
// - Configuration write switches reads to burst mode
// - Burst data follows host clock edges
// - Wait output holds host off until valid
// - Burst lengths four, eight, sixteen, continuous
// - Page reads serve sixteen-word pages
// - Command front end decodes host writes
// - Write sequencer runs erase and program alone
// - Status shows completion and errors
// - One erase clears exactly one block
// - Suspended erase allows other-block read; program waits for resume and replaces the erase
// - Suspended program allows reads elsewhere
// - Programming is whole sixteen-bit words only
// - Write buffer holds up to 512 words
// - Four parameter blocks top or bottom
// - Blank check verifies a block is erased
// - Lock and unlock apply at once
// - OTP has factory part and user part
// - Low program supply refuses program, erase
// - Address bit 25, or bit 24 when stacked, picks die under select
// - Stacked variant uses address line 24
// - Grid variant uses address line 25
// - Address taken at strobe rise or clock
// - Deselect floats data and wait outputs
// - Reset stops sequencer and blocks writes
`ifndef FHD_DEFINES_VH
`define FHD_DEFINES_VH
// ==========================================================
// Sizes
`define FHD_ADDR_W       26
`define FHD_DATA_W       16
`define FHD_WORD_ADDR_W  10
`define FHD_BLK_W        3
`define FHD_NUM_BLK      8
`define FHD_PAGE_W       4
`define FHD_BUF_MAX      10'h1ff
`define FHD_BIT_STACKED  24
`define FHD_BIT_GRID     25
// ==========================================================
// Command codes (coined)
`define FHD_CMD_READ     8'hff
`define FHD_CMD_STATUS   8'h70
`define FHD_CMD_CLRSTS   8'h50
`define FHD_CMD_PROG     8'h40
`define FHD_CMD_BUFPROG  8'he8
`define FHD_CMD_ERASE    8'h20
`define FHD_CMD_BLANK    8'hbc
`define FHD_CMD_CONFIRM  8'hd0
`define FHD_CMD_SUSPEND  8'hb0
`define FHD_CMD_LOCKSET  8'h60
`define FHD_CMD_LOCK     8'h01
`define FHD_CMD_CONFIG   8'h03
`define FHD_CMD_OTP      8'hc0
// ==========================================================
// Status bits
`define FHD_ST_READY     7
`define FHD_ST_ESUSP     6
`define FHD_ST_ERASE_ERR 5
`define FHD_ST_PROG_ERR  4
`define FHD_ST_VPP_ERR   3
`define FHD_ST_PSUSP     2
`define FHD_ST_LOCK_ERR  1
// ==========================================================
// Timing in ns and cycles at 40 MHz
`define FHD_CLK_NS       25
`define FHD_PROG_NS      1000
`define FHD_PROG_CYC     16'h0028
`define FHD_ERASE_NS     4000
`define FHD_ERASE_CYC    16'h00a0
`define FHD_LAT_CYC      4'h3
`endif

/* File: hdl/fhd_flash_die.v */
// Flash die pair: command front end, write sequencer, read paths
`timescale 1ns/1ps
`include "fhd_defines.vh"
module fhd_flash_die #(
   parameter GRID_PKG = 1,   // 1: die bit is line 25, 0: line 24
   parameter TOP_PARAM = 0   // Parameter blocks at the top when 1
) (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        arst_n,
   // Host bus pins
   input  wire [25:0] addr,
   input  wire [15:0] dq_in,
   output reg  [15:0] dq_out,
   output reg         dq_oe_n,
   output reg         wait_out,
   output reg         wait_oe_n,
   input  wire        shared_die_select_n,
   input  wire        output_enable_n,
   input  wire        write_enable_n,
   input  wire        address_latch_strobe_n,
   input  wire        link_clk,
   input  wire        supply_above_lockout,
   // Observation of the selected die
   output reg         upper_die_active,
   output reg         burst_mode
);
   // ==========================================================
   // Pin synchronisers
   reg  [5:0] sync1;  // First stage, read only by sync2
   reg  [5:0] sync2;  // Stable copies
   reg  [5:0] sync3;  // History for edge find
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         // Idle pin levels, so no false edge follows reset
         sync1 <= 6'h2f;
         sync2 <= 6'h2f;
         sync3 <= 6'h2f;
      end else begin
         sync1 <= {supply_above_lockout, link_clk, address_latch_strobe_n,
                   write_enable_n, output_enable_n, shared_die_select_n};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   wire ce_n   = sync2[0];
   wire oe_n   = sync2[1];
   wire we_n   = sync2[2];
   wire als_n  = sync2[3];
   wire lclk   = sync2[4];
   wire vpp_ok = sync2[5];
   wire clk_rise = lclk & ~sync3[4];
   wire als_rise = als_n & ~sync3[3];
   wire we_rise  = we_n & ~sync3[2];
   // Bus pins settle long before strobes; sampled twice as well
   reg  [41:0] bus_s1;  // First stage, read only by bus_s
   reg  [41:0] bus_s;   // Address above data
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_s1 <= 42'h0;
         bus_s <= 42'h0;
      end else begin
         bus_s1 <= {addr, dq_in};
         bus_s <= bus_s1;
      end
   end
   wire [25:0] addr_s = bus_s[41:16];
   wire [15:0] din_s  = bus_s[15:0];
   // ==========================================================
   // Die decode
   // stacked uses line 24
   wire die_bit = GRID_PKG ? addr_s[`FHD_BIT_GRID] : addr_s[`FHD_BIT_STACKED];
   wire sel = ~ce_n;
   // Both dies of the pair modelled together; array index carries die
   wire [10:0] waddr = {die_bit, addr_s[9:0]};
   // ==========================================================
   // Array, lock bits, OTP
   reg [15:0] mem [0:2047];         // Tiny array image, both dies
   reg [15:0] otp [0:15];           // Words 0-3 factory, 4-15 user
   reg [`FHD_NUM_BLK*2-1:0] lock;  // One lock bit per block per die
   integer k;  // Array starts erased, as shipped
   initial for (k = 0; k < 2048; k = k + 1) mem[k] = 16'hffff;
   // four small parameter blocks top or bottom
   function [3:0] blk_of;
      input [10:0] a;
      if (TOP_PARAM != 0)
         blk_of = {a[10], (a[9:8] == 2'h3) ? {1'b1, a[7:6]} : {1'b0, a[9:8]}};
      else
         blk_of = {a[10], (a[9:8] == 2'h0) ? {1'b0, a[7:6]} : {1'b1, a[9:8]}};
   endfunction
   function [10:0] blk_base;
      input [3:0] b;
      if (TOP_PARAM != 0)
         blk_base = b[2] ? {b[3], 2'h3, b[1:0], 6'h0} : {b[3], b[1:0], 8'h0};
      else
         blk_base = b[2] ? {b[3], b[1:0], 8'h0} : {b[3], 2'h0, b[1:0], 6'h0};
   endfunction
   // ==========================================================
   // Front end and sequencer states
   localparam S_READ = 4'h0, S_STAT = 4'h1, S_PROG = 4'h2, S_BUFCNT = 4'h3;
   localparam S_BUFDAT = 4'h4, S_BUFCFM = 4'h5, S_ERASE = 4'h6, S_BLANK = 4'h7;
   localparam S_LOCK = 4'h8, S_CFG = 4'h9, S_OTP = 4'ha, S_BUSY = 4'hb;
   localparam OP_NONE = 2'h0, OP_PROG = 2'h1, OP_ERASE = 2'h2, OP_BLANK = 2'h3;
   reg [3:0]  fe_state;     // Command front end state
   reg [1:0]  op;           // Sequencer operation
   reg [15:0] timer;        // Sequencer algorithm timer
   reg [10:0] op_addr;      // Current target word
   reg [10:0] op_end;       // Last word of a block operation
   reg [8:0]  buf_cnt;      // Words left in the buffer, less one
   reg [8:0]  buf_n;        // Words loaded
   reg [15:0] wbuf [0:511]; // write buffer, 512 words
   reg [8:0]  buf_rd;       // Commit pointer
   reg [7:0]  status;       // Status register
   reg        esusp;        // Erase suspended
   reg        psusp;        // Program suspended
   reg [10:0] susp_addr;    // Target frozen by erase suspend
   reg [15:0] cfg;          // Read configuration
   wire busy = (op != OP_NONE) & ~esusp & ~psusp;
   wire [7:0] cmd = din_s[7:0];
   wire       wr = sel & we_rise;
   wire [3:0] tgt_blk = blk_of(waddr);
   wire [10:0] blk_last = (tgt_blk[2] ^ (TOP_PARAM != 0)) ? 11'h0ff : 11'h03f; // Length less one
   // Word-program target in the suspended erase block is refused
   wire susp_hit = esusp & (tgt_blk == blk_of(susp_addr));
   // every write cycle is decoded here
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         fe_state <= S_READ;
         op <= OP_NONE;
         timer <= 16'h0;
         op_addr <= 11'h0;
         op_end <= 11'h0;
         buf_cnt <= 9'h0;
         buf_n <= 9'h0;
         buf_rd <= 9'h0;
         status <= 8'h80;
         esusp <= 1'b0;
         psusp <= 1'b0;
         susp_addr <= 11'h0;
         cfg <= 16'h0;
         lock <= {(`FHD_NUM_BLK*2){1'b1}};
      end else begin
         if (busy) begin
            if (timer != 16'h0) begin
               timer <= timer - 16'h1;
            end else if (op == OP_PROG) begin
               mem[op_addr] <= mem[op_addr] & wbuf[buf_rd];
               if (buf_cnt == 9'h0) begin
                  op <= OP_NONE;
                  status[`FHD_ST_READY] <= 1'b1;
               end else begin
                  buf_cnt <= buf_cnt - 9'h1;
                  buf_rd <= buf_rd + 9'h1;
                  op_addr <= op_addr + 11'h1;
                  timer <= `FHD_PROG_CYC;
               end
            end else if (op == OP_ERASE) begin
               mem[op_addr] <= 16'hffff;
               op_addr <= op_addr + 11'h1;
               if (op_addr == op_end) begin
                  op <= OP_NONE;
                  status[`FHD_ST_READY] <= 1'b1;
               end
            end else begin
               if (mem[op_addr] != 16'hffff)
                  status[`FHD_ST_ERASE_ERR] <= 1'b1;
               op_addr <= op_addr + 11'h1;
               if (op_addr == op_end) begin
                  op <= OP_NONE;
                  status[`FHD_ST_READY] <= 1'b1;
               end
            end
         end
         if (wr) begin
            case (fe_state)
               S_PROG: begin
                  if (!vpp_ok) begin
                     status[`FHD_ST_VPP_ERR] <= 1'b1;
                     status[`FHD_ST_PROG_ERR] <= 1'b1;
                  end else if (lock[tgt_blk] || susp_hit) begin
                     status[`FHD_ST_LOCK_ERR] <= 1'b1;
                     status[`FHD_ST_PROG_ERR] <= 1'b1;
                  end else begin
                     wbuf[0] <= din_s;
                     buf_rd <= 9'h0;
                     buf_cnt <= 9'h0;
                     op_addr <= waddr;
                     op <= OP_PROG;
                     timer <= `FHD_PROG_CYC;
                     status[`FHD_ST_READY] <= 1'b0;
                  end
                  fe_state <= S_STAT;
               end
               S_BUFCNT: begin
                  buf_cnt <= din_s[8:0];
                  buf_n <= 9'h0;
                  op_addr <= waddr;
                  fe_state <= S_BUFDAT;
               end
               S_BUFDAT: begin
                  wbuf[buf_n] <= din_s;
                  buf_n <= buf_n + 9'h1;
                  if (buf_n == buf_cnt)
                     fe_state <= S_BUFCFM;
               end
               S_BUFCFM: begin
                  if (cmd == `FHD_CMD_CONFIRM && vpp_ok && !lock[blk_of(op_addr)]) begin
                     buf_rd <= 9'h0;
                     op <= OP_PROG;
                     timer <= `FHD_PROG_CYC;
                     status[`FHD_ST_READY] <= 1'b0;
                  end else begin
                     status[`FHD_ST_PROG_ERR] <= 1'b1;
                     status[`FHD_ST_VPP_ERR] <= ~vpp_ok;
                  end
                  fe_state <= S_STAT;
               end
               S_ERASE, S_BLANK: begin
                  if (cmd != `FHD_CMD_CONFIRM || !vpp_ok || esusp ||
                      (fe_state == S_ERASE && lock[tgt_blk])) begin
                     status[`FHD_ST_ERASE_ERR] <= 1'b1;
                     status[`FHD_ST_VPP_ERR] <= ~vpp_ok;
                  end else begin
                     op_addr <= blk_base(tgt_blk);
                     op_end <= blk_base(tgt_blk) + blk_last;
                     op <= (fe_state == S_ERASE) ? OP_ERASE : OP_BLANK;
                     timer <= `FHD_ERASE_CYC;
                     status[`FHD_ST_READY] <= 1'b0;
                  end
                  fe_state <= S_STAT;
               end
               S_LOCK: begin
                  if (cmd == `FHD_CMD_LOCK)
                     lock[tgt_blk] <= 1'b1;
                  else if (cmd == `FHD_CMD_CONFIRM)
                     lock[tgt_blk] <= 1'b0;
                  else if (cmd == `FHD_CMD_CONFIG)
                     cfg <= addr_s[15:0];
                  fe_state <= S_READ;
               end
               S_OTP: begin
                  if (addr_s[3:2] == 2'h0 || !vpp_ok)
                     status[`FHD_ST_PROG_ERR] <= 1'b1;
                  else
                     otp[addr_s[3:0]] <= otp[addr_s[3:0]] & din_s;
                  fe_state <= S_STAT;
               end
               default: begin
                  case (cmd)
                     `FHD_CMD_STATUS: fe_state <= S_STAT;
                     `FHD_CMD_CLRSTS: if (!busy) status[5:1] <= 5'h0;
                     `FHD_CMD_PROG: fe_state <= busy ? S_STAT : S_PROG;
                     `FHD_CMD_BUFPROG: fe_state <= busy ? S_STAT : S_BUFCNT;
                     `FHD_CMD_ERASE: fe_state <= busy ? S_STAT : S_ERASE;
                     `FHD_CMD_BLANK: fe_state <= busy ? S_STAT : S_BLANK;
                     `FHD_CMD_LOCKSET: fe_state <= S_LOCK;
                     `FHD_CMD_OTP: fe_state <= S_OTP;
                     `FHD_CMD_SUSPEND: begin
                        if (busy && op == OP_ERASE) begin
                           esusp <= 1'b1;
                           susp_addr <= op_addr;
                           status[`FHD_ST_ESUSP] <= 1'b1;
                           status[`FHD_ST_READY] <= 1'b1;
                        end else if (busy && op == OP_PROG) begin
                           psusp <= 1'b1;
                           status[`FHD_ST_PSUSP] <= 1'b1;
                           status[`FHD_ST_READY] <= 1'b1;
                        end
                        fe_state <= S_STAT;
                     end
                     `FHD_CMD_CONFIRM: begin
                        esusp <= 1'b0;
                        psusp <= 1'b0;
                        status[`FHD_ST_ESUSP] <= 1'b0;
                        status[`FHD_ST_PSUSP] <= 1'b0;
                        status[`FHD_ST_READY] <= ~(esusp | psusp);
                        fe_state <= S_STAT;
                     end
                     default: fe_state <= S_READ;
                  endcase
               end
            endcase
         end
      end
   end
   // ==========================================================
   // Read paths
   localparam B_IDLE = 2'h0, B_LAT = 2'h1, B_DATA = 2'h2;
   reg [1:0]  bst;       // Burst state
   reg [10:0] baddr;     // Burst address
   reg [3:0]  lat;       // Latency countdown
   reg [4:0]  bleft;     // Wrap length latched at capture, never counted down
   wire [4:0] blen = (cfg[2:0] == 3'h1) ? 5'h4 : (cfg[2:0] == 3'h2) ? 5'h8 :
                     (cfg[2:0] == 3'h3) ? 5'h10 : 5'h0;
   wire [15:0] word = (fe_state == S_STAT || busy) ? {8'h0, status} : mem[waddr];
   // Burst engine on sampled link clock edges
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bst <= B_IDLE;
         baddr <= 11'h0;
         lat <= 4'h0;
         bleft <= 5'h0;
         burst_mode <= 1'b0;
      end else begin
         burst_mode <= cfg[15];
         if (!sel || !cfg[15]) begin
            bst <= B_IDLE;
         // capture on strobe rise or clock with strobe low
         end else if ((als_rise || (clk_rise && !als_n)) && bst != B_LAT) begin
            bst <= B_LAT;
            baddr <= waddr;
            lat <= `FHD_LAT_CYC;
            bleft <= blen;
         end else if (clk_rise) begin
            if (bst == B_LAT) begin
               if (lat == 4'h0)
                  bst <= B_DATA;
               else
                  lat <= lat - 4'h1;
            end else if (bst == B_DATA) begin
               // wrap within 4/8/16, or run on
               if (blen == 5'h0)
                  baddr <= baddr + 11'h1;
               else
                  baddr <= {baddr[10:4], (baddr[3:0] + 4'h1) & (blen[3:0] - 4'h1) |
                            baddr[3:0] & ~(blen[3:0] - 4'h1)};
            end
         end
      end
   end
   // Output pins
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dq_out <= 16'h0;
         dq_oe_n <= 1'b1;
         wait_out <= 1'b0;
         wait_oe_n <= 1'b1;
         upper_die_active <= 1'b0;
      end else begin
         upper_die_active <= sel & die_bit;
         dq_oe_n <= ce_n | oe_n | ~we_n;
         wait_oe_n <= ce_n | oe_n;
         wait_out <= cfg[15] & (bst != B_DATA);
         if (cfg[15] && bst == B_DATA)
            dq_out <= mem[baddr];
         else if (!cfg[15])
            // page word chosen by low bits, same page stays fast
            dq_out <= (fe_state == S_OTP) ? otp[addr_s[3:0]] : word;
      end
   end
endmodule // fhd_flash_die

/* File: test/fhd_props.sv */
// Pin-level concurrent checks for the flash die pair
`timescale 1ns/1ps
module fhd_props (
   // Clock and reset
   input wire        ref_clk,
   input wire        arst_n,
   // Host bus pins
   input wire [25:0] addr,
   input wire [15:0] dq_in,
   input wire [15:0] dq_out,
   input wire        dq_oe_n,
   input wire        wait_out,
   input wire        wait_oe_n,
   input wire        shared_die_select_n,
   input wire        output_enable_n,
   input wire        write_enable_n,
   input wire        address_latch_strobe_n,
   input wire        link_clk,
   input wire        supply_above_lockout,
   // Observation
   input wire        upper_die_active,
   input wire        burst_mode
);
   // ==========================================================
   // One domain, so clock and reset are given once
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // Windows of five or six allow for the input synchronisers
   deselect_float_a: assert property (shared_die_select_n [*5] |-> dq_oe_n && wait_oe_n)
      else $error("outputs driven while deselected");
   oe_float_a: assert property (output_enable_n [*5] |-> dq_oe_n && wait_oe_n)
      else $error("outputs driven with output enable high");
   read_drive_a: assert property ((!shared_die_select_n && !output_enable_n && write_enable_n)
      [*6] |-> !dq_oe_n) else $error("data not driven during read");
   upper_die_a: assert property ((!shared_die_select_n && addr[25]) [*5] |-> upper_die_active)
      else $error("upper die not picked");
   lower_die_a: assert property ((!shared_die_select_n && !addr[25]) [*5] |-> !upper_die_active)
      else $error("upper die picked with low die bit");
   // Mode only moves after a write has been taken
   mode_hold_a: assert property (write_enable_n [*8] |=> $stable(burst_mode))
      else $error("read mode changed without a write");
   reset_mode_a: assert property ($rose(arst_n) |-> dq_oe_n && wait_oe_n && !burst_mode)
      else $error("reset did not restore asynchronous read");
   // No link rise for several cycles means burst data must hold
   burst_hold_a: assert property ((burst_mode && !link_clk && address_latch_strobe_n
      && !shared_die_select_n && !output_enable_n) [*4] |-> $stable(dq_out))
      else $error("burst data moved between link edges");
endmodule // fhd_props

/* File: test/fhd_host_model.sv */
// Host processor model driving the flash bus pins
`timescale 1ns/1ps
`include "fhd_defines.vh"
module fhd_host_model (
   // Clock
   input  wire        ref_clk,
   // Bus pins toward the device
   output reg  [25:0] addr,
   output reg  [15:0] dq_in,
   output reg         shared_die_select_n,
   output reg         output_enable_n,
   output reg         write_enable_n,
   output reg         address_latch_strobe_n,
   // Data back from the device
   input  wire [15:0] dq_out
);
   // ==========================================================
   // Idle bus at time zero
   initial begin
      addr = 26'h0000000;
      dq_in = 16'h0000;
      shared_die_select_n = 1'b1;
      output_enable_n = 1'b1;
      write_enable_n = 1'b1;
      address_latch_strobe_n = 1'b1;
   end
   // ==========================================================
   // Write cycle with generous setup and hold for the synchronisers
   // bus write cycle
   task wr(input [25:0] a, input [15:0] d);
      begin
         @(posedge ref_clk);
         addr <= a;
         dq_in <= d;
         shared_die_select_n <= 1'b0;
         repeat (4) @(posedge ref_clk);
         write_enable_n <= 1'b0;
         repeat (4) @(posedge ref_clk);
         write_enable_n <= 1'b1;
         repeat (4) @(posedge ref_clk);
         // Released data shows the inverse, never the stale word
         dq_in <= ~d;
         shared_die_select_n <= 1'b1;
         repeat (4) @(posedge ref_clk);
      end
   endtask
   // Read cycle; sampled at the edge, before the edge's own updates
   task rd(input [25:0] a, output [15:0] d);
      begin
         @(posedge ref_clk);
         addr <= a;
         shared_die_select_n <= 1'b0;
         output_enable_n <= 1'b0;
         repeat (7) @(posedge ref_clk);
         d = dq_out;
         shared_die_select_n <= 1'b1;
         output_enable_n <= 1'b1;
      end
   endtask
   task pins(input [25:0] a, input ce_n, input oe_n, input str_n);
      begin
         @(posedge ref_clk);
         addr <= a;
         shared_die_select_n <= ce_n;
         output_enable_n <= oe_n;
         address_latch_strobe_n <= str_n;
      end
   endtask
   task poll(output [15:0] s, output ok);
      integer n;
      begin
         ok = 1'b0;
         wr(26'h0000000, `FHD_CMD_STATUS);
         for (n = 0; n < 100 && !ok; n = n + 1) begin
            rd(26'h0000000, s);
            ok = s[`FHD_ST_READY];
         end
      end
   endtask
endmodule // fhd_host_model

/* File: test/fhd_flash_die_tb.sv */
// Self-checking bench for the flash die pair
`timescale 1ns/1ps
`include "fhd_defines.vh"
`define CHK(got, exp) begin check_count = check_count + 1; if ((got) !== (exp)) begin \
   mismatches = mismatches + 1; $display("mismatch at %0t: got %h want %h", $time, got, exp); end end
module fhd_flash_die_tb;
   // ==========================================================
   // Bench signals
   reg         ref_clk;
   reg         arst_n;
   reg         link_clk;
   reg         supply_above_lockout;
   wire [25:0] addr;
   wire [15:0] dq_in;
   wire [15:0] dq_out;
   wire        dq_oe_n, wait_out, wait_oe_n, upper_die_active, burst_mode;
   wire        shared_die_select_n, output_enable_n, write_enable_n, address_latch_strobe_n;
   integer     mismatches, check_count, i;
   reg  [15:0] s;
   reg         ok;
   fhd_flash_die u_fhd_flash_die (.*);
   fhd_host_model u_fhd_host_model (.ref_clk(ref_clk), .addr(addr), .dq_in(dq_in),
      .shared_die_select_n(shared_die_select_n), .output_enable_n(output_enable_n),
      .write_enable_n(write_enable_n), .address_latch_strobe_n(address_latch_strobe_n),
      .dq_out(dq_out));
   always #12.5 ref_clk = ~ref_clk;
   // ==========================================================
   // Helpers
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", check_count, mismatches);
         if (mismatches == 0 && check_count > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task cmd2(input [25:0] a, input [15:0] c, input [15:0] d);
      begin
         u_fhd_host_model.wr(a, c);
         u_fhd_host_model.wr(a, d);
      end
   endtask
   // Bounded poll; a stuck sequencer ends the run
   task wait_ready;
      begin
         u_fhd_host_model.poll(s, ok);
         if (!ok) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: sequencer never ready", $time);
            stop_test;
         end
      end
   endtask
   task chk_word(input [25:0] a, input [15:0] exp);
      begin
         u_fhd_host_model.wr(a, `FHD_CMD_READ);
         u_fhd_host_model.rd(a, s);
         `CHK(s, exp)
      end
   endtask
   // ==========================================================
   // Locked refusal, unlock at once, program and read back
   task t_program;
      begin
         cmd2(26'h0000100, `FHD_CMD_PROG, 16'h1234);
         wait_ready;
         `CHK({s[1], s[4]}, 2'b11)
         u_fhd_host_model.wr(26'h0000100, `FHD_CMD_CLRSTS);
         cmd2(26'h0000100, `FHD_CMD_LOCKSET, `FHD_CMD_CONFIRM);
         cmd2(26'h0000200, `FHD_CMD_LOCKSET, `FHD_CMD_CONFIRM);
         for (i = 0; i < 4; i = i + 1) begin
            cmd2(26'h0000100 + i, `FHD_CMD_PROG, 16'ha5c0 | i);
            wait_ready;
            `CHK(s[7:0], 8'h80)
         end
         cmd2(26'h0000200, `FHD_CMD_PROG, 16'h3c3c);
         wait_ready;
         for (i = 0; i < 4; i = i + 1)
            chk_word(26'h0000100 + i, 16'ha5c0 | i);
      end
   endtask
   // Low programming supply refuses the write
   task t_supply;
      begin
         supply_above_lockout <= 1'b0;
         cmd2(26'h0000104, `FHD_CMD_PROG, 16'h0000);
         wait_ready;
         `CHK({s[3], s[4]}, 2'b11)
         supply_above_lockout <= 1'b1;
         u_fhd_host_model.wr(26'h0000100, `FHD_CMD_CLRSTS);
         chk_word(26'h0000104, 16'hffff);
      end
   endtask
   // Die pick by the top bit, then deselect floats
   task t_die;
      begin
         u_fhd_host_model.pins(26'h2000100, 1'b0, 1'b1, 1'b1);
         repeat (6) @(posedge ref_clk);
         `CHK(upper_die_active, 1'b1)
         u_fhd_host_model.pins(26'h1000100, 1'b0, 1'b1, 1'b1);
         repeat (6) @(posedge ref_clk);
         `CHK(upper_die_active, 1'b0)
         u_fhd_host_model.pins(26'h1000100, 1'b1, 1'b0, 1'b1);
         repeat (6) @(posedge ref_clk);
         `CHK({dq_oe_n, wait_oe_n}, 2'b11)
      end
   endtask
   // Configure a four-word burst and read it on the link clock
   task t_burst;
      begin
         cmd2(26'h0008001, `FHD_CMD_LOCKSET, `FHD_CMD_CONFIG);
         `CHK(burst_mode, 1'b1)
         u_fhd_host_model.pins(26'h0000100, 1'b0, 1'b0, 1'b0);
         fork
            begin
               #37;
               repeat (11) begin
                  link_clk = 1'b1;
                  #100;
                  link_clk = 1'b0;
                  #100;
               end
            end
            begin
               @(posedge link_clk);
               repeat (4) @(posedge ref_clk);
               // Address moved away after the strobe: the latched one must serve
               u_fhd_host_model.pins(26'h0000000, 1'b0, 1'b0, 1'b1);
               @(posedge ref_clk);
               `CHK(wait_out, 1'b1)
               for (i = 0; i < 200 && wait_out !== 1'b0; i = i + 1)
                  @(posedge ref_clk);
               `CHK(wait_out, 1'b0)
               for (i = 0; i < 4; i = i + 1) begin
                  `CHK(dq_out, 16'ha5c0 | i)
                  @(posedge link_clk);
                  repeat (5) @(posedge ref_clk);
               end
            end
         join
         u_fhd_host_model.pins(26'h0000000, 1'b1, 1'b1, 1'b1);
      end
   endtask
   // Reset in mid-run returns to asynchronous reads
   task t_reset;
      begin
         arst_n <= 1'b0;
         repeat (5) @(posedge ref_clk);
         arst_n <= 1'b1;
         repeat (4) @(posedge ref_clk);
         `CHK(burst_mode, 1'b0)
         u_fhd_host_model.rd(26'h0000101, s);
         `CHK(s, 16'ha5c1)
      end
   endtask
   // Erase clears its own block only
   task t_erase;
      begin
         cmd2(26'h0000100, `FHD_CMD_LOCKSET, `FHD_CMD_CONFIRM);
         cmd2(26'h0000100, `FHD_CMD_ERASE, `FHD_CMD_CONFIRM);
         wait_ready;
         `CHK(s[7:0], 8'h80)
         chk_word(26'h0000103, 16'hffff);
         chk_word(26'h0000200, 16'h3c3c);
      end
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      ref_clk = 1'b0;
      arst_n = 1'b0;
      link_clk = 1'b0;
      supply_above_lockout = 1'b1;
      mismatches = 0;
      check_count = 0;
      repeat (5) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_program;
      t_supply;
      t_die;
      t_burst;
      t_reset;
      t_erase;
      stop_test;
   end
endmodule // fhd_flash_die_tb
bind fhd_flash_die fhd_props u_fhd_props (.*);
